// *** verilog/gdp_defines.svh ***
// Constants for the address-decoded general-purpose pin block.
// Assumes inclusion by bare name from the block's design files.
`ifndef GDP_DEFINES_SVH
`define GDP_DEFINES_SVH

// ----------------------------------------------------------------
// Configuration register indices
// ----------------------------------------------------------------
`define GDP_IDX_PIN0_ADDR_LO 8'h10
`define GDP_IDX_PIN0_CMP_HI  8'h11
`define GDP_IDX_PIN1_ADDR_LO 8'h12
`define GDP_IDX_PIN1_CMP_HI  8'h13
`define GDP_IDX_PIN0_FUNC    8'h14
`define GDP_IDX_PIN1_FUNC    8'h15
`define GDP_IDX_FIRST        8'h10
`define GDP_IDX_LAST         8'h15
`define GDP_NUM_CFG          6

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define GDP_CFG_RESET        8'h00
`define GDP_INDEX_RESET      8'h00
`define GDP_CMP_HI_MASK      8'hc7
`define GDP_FULL_MASK        8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GDP_AHI_MSB          2
`define GDP_AHI_LSB          0
`define GDP_CMPW_MSB         7
`define GDP_CMPW_LSB         6
`define GDP_FN_MSB           7
`define GDP_FN_LSB           5
`define GDP_CSPOL_BIT        4
`define GDP_CSRD_BIT         3
`define GDP_CSWR_BIT         2
`define GDP_OINV_BIT         1
`define GDP_IINV_BIT         0

`endif

// *** verilog/gdp_pkg.sv ***
// Types shared by the decoded-pin block.
// Assumes nothing of its surroundings.
package gdp_pkg;

  // ----------------------------------------------------------------
  // Pin function codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GDP_FN_OFF   = 3'b000,
    GDP_FN_OUT   = 3'b001,
    GDP_FN_IN    = 3'b010,
    GDP_FN_BIDIR = 3'b011,
    GDP_FN_CS0   = 3'b100,
    GDP_FN_CS1   = 3'b101,
    GDP_FN_CS2   = 3'b110,
    GDP_FN_CS3   = 3'b111
  } gdp_func_t;

  // ----------------------------------------------------------------
  // State of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      index;
    logic [5:0][7:0] cfg;
    logic [1:0]      latch;
    logic [1:0]      pin_o;
    logic [1:0]      pin_oe;
    logic [7:0]      sd_o;
    logic [7:0]      sd_oe;
  } gdp_state_t;

  // Masked compare of a programmed address against the bus address.
  function automatic logic gdp_addr_match(input logic [10:0] prog,
                                          input logic [10:0] sa,
                                          input logic [1:0]  width);
    logic [10:0] mask;
    mask = 11'h7ff << width;
    return ((prog ^ sa) & mask) == 11'h000;
  endfunction : gdp_addr_match

endpackage : gdp_pkg

// *** verilog/gdp_pin_if.sv ***
// Carrier between the top module and one pin decoder.
// Assumes the top drives configuration and bus levels each cycle.
`timescale 1ns/1ps

interface gdp_pin_if;
  logic [7:0]       addr_lo;
  logic [7:0]       cmp_hi;
  logic [7:0]       func_ctl;
  logic [10:0]      sa;
  logic             aen;
  logic             ior_n;
  logic             iow_n;
  logic             hit;
  logic             cs_active;
  logic             out_inv;
  logic             in_inv;
  logic             cs_high;
  gdp_pkg::gdp_func_t func;

  modport top (output addr_lo, cmp_hi, func_ctl, sa, aen, ior_n, iow_n,
               input hit, cs_active, out_inv, in_inv, cs_high, func);
  modport dec (input addr_lo, cmp_hi, func_ctl, sa, aen, ior_n, iow_n,
               output hit, cs_active, out_inv, in_inv, cs_high, func);
endinterface : gdp_pin_if

// *** verilog/gdp_pin_decode.sv ***
// Address decoder and field splitter for one decoded pin.
// Assumes bus inputs are synchronous and the caller registers results.
`timescale 1ns/1ps
`include "gdp_defines.svh"

module gdp_pin_decode (
  gdp_pin_if.dec pif
);

  logic [10:0] prog_addr;
  logic [1:0]  width;
  logic        qual_rd;
  logic        qual_wr;
  logic        strobe_ok;

  // ----------------------------------------------------------------
  // Address compare
  // ----------------------------------------------------------------
  // High address bits.
  // Low byte and high bits form the eleven-bit match address.
  assign prog_addr = {pif.cmp_hi[`GDP_AHI_MSB:`GDP_AHI_LSB], pif.addr_lo};
  // Compare width picks how many low bits are ignored.
  assign width     = pif.cmp_hi[`GDP_CMPW_MSB:`GDP_CMPW_LSB];
  // A hit needs the address enable low and a masked match.
  assign pif.hit   = ~pif.aen & gdp_pkg::gdp_addr_match(prog_addr, pif.sa, width);

  // ----------------------------------------------------------------
  // Function fields
  // ----------------------------------------------------------------
  // The top three bits pick the pin function.
  assign pif.func    = gdp_pkg::gdp_func_t'(pif.func_ctl[`GDP_FN_MSB:`GDP_FN_LSB]);
  // Polarity of the chip select.
  assign pif.cs_high = pif.func_ctl[`GDP_CSPOL_BIT];
  // Inversion of bus-to-pin and pin-to-bus paths.
  assign pif.out_inv = pif.func_ctl[`GDP_OINV_BIT];
  assign pif.in_inv  = pif.func_ctl[`GDP_IINV_BIT];

  // Strobe qualification: none, write, read, or either strobe.
  assign qual_rd   = pif.func_ctl[`GDP_CSRD_BIT];
  assign qual_wr   = pif.func_ctl[`GDP_CSWR_BIT];
  assign strobe_ok = (~qual_rd & ~qual_wr)
                   | (qual_wr & ~pif.iow_n)
                   | (qual_rd & ~pif.ior_n);
  assign pif.cs_active = pif.hit & strobe_ok;

endmodule : gdp_pin_decode

// *** verilog/gdp_decoded_pins.sv ***
// Top of the address-decoded general-purpose pin block.
// Assumes ISA-side signals synchronous to clk_i; the pad logic resolves
// the pins and the data bus from the output enables.
//
// Behaviour
// - Config registers 10h-15h reached via index then data port in extended mode.
// - All pin configuration registers reset to zero; pins inactive.
// - Index 10h holds pin zero match address bits 7-0.
// - Index 11h bits 2-0 hold pin zero address bits 10-8; 5-3 reserved.
// - Index 11h bits 7-6 set how many low address bits pin zero ignores.
// - Pin one address sits in index 12h and index 13h bits 2-0.
// - Index 13h bits 7-6 set pin one compare width alike.
// - Index 14h bits 7-5 select pin zero function; 000 tri-states it.
// - Function 001 puts data bit onto pin on matching write.
// - Function 010 puts pin level onto data bit on matching read.
// - Function 011 passes both directions on matching cycles.
// - Function 1xx makes pin a chip select on address match.
// - Bit 4 sets chip select polarity: 0 low, 1 high active.
// - Bits 3-2 qualify chip select with none, write, read, either strobe.
// - Bit 1 inverts bus-to-pin path, bit 0 inverts pin-to-bus path.
// - Index 15h configures pin one with identical encodings.
`timescale 1ns/1ps
`include "gdp_defines.svh"

module gdp_decoded_pins #(
  parameter logic [10:0] INDEX_PORT_ADDR = 11'h100,
  parameter logic [10:0] DATA_PORT_ADDR  = 11'h101
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ext_mode_i,
  input  wire logic        aen_i,
  input  wire logic        ior_n_i,
  input  wire logic        iow_n_i,
  input  wire logic [10:0] sa_i,
  input  wire logic [7:0]  sd_i,
  output logic      [7:0]  sd_o,
  output logic      [7:0]  sd_oe_o,
  input  wire logic [1:0]  pin_i,
  output logic      [1:0]  pin_o,
  output logic      [1:0]  pin_oe_o
);

  // ----------------------------------------------------------------
  // State and helper functions
  // ----------------------------------------------------------------
  gdp_pkg::gdp_state_t state;
  gdp_pkg::gdp_state_t next_state;

  // True when an index falls on one of this block's registers.
  function automatic logic cfg_owned(input logic [7:0] idx);
    return (idx >= `GDP_IDX_FIRST) && (idx <= `GDP_IDX_LAST);
  endfunction : cfg_owned

  // Slot of a register in the storage array.
  function automatic logic [2:0] cfg_slot(input logic [7:0] idx);
    logic [7:0] diff;
    diff = idx - `GDP_IDX_FIRST;
    return diff[2:0];
  endfunction : cfg_slot

  // Writable bits of a register; reserved bits stay zero.
  function automatic logic [7:0] cfg_mask(input logic [7:0] idx);
    logic [7:0] m;
    m = `GDP_FULL_MASK;
    if (idx == `GDP_IDX_PIN0_CMP_HI || idx == `GDP_IDX_PIN1_CMP_HI) begin
      m = `GDP_CMP_HI_MASK;
    end
    return m;
  endfunction : cfg_mask

  // ----------------------------------------------------------------
  // Pin decoders
  // ----------------------------------------------------------------
  gdp_pin_if pif0 ();
  gdp_pin_if pif1 ();

  assign pif0.addr_lo  = state.cfg[cfg_slot(`GDP_IDX_PIN0_ADDR_LO)];
  assign pif0.cmp_hi   = state.cfg[cfg_slot(`GDP_IDX_PIN0_CMP_HI)];
  assign pif0.func_ctl = state.cfg[cfg_slot(`GDP_IDX_PIN0_FUNC)];
  assign pif0.sa       = sa_i;
  assign pif0.aen      = aen_i;
  assign pif0.ior_n    = ior_n_i;
  assign pif0.iow_n    = iow_n_i;

  assign pif1.addr_lo  = state.cfg[cfg_slot(`GDP_IDX_PIN1_ADDR_LO)];
  assign pif1.cmp_hi   = state.cfg[cfg_slot(`GDP_IDX_PIN1_CMP_HI)];
  assign pif1.func_ctl = state.cfg[cfg_slot(`GDP_IDX_PIN1_FUNC)];
  assign pif1.sa       = sa_i;
  assign pif1.aen      = aen_i;
  assign pif1.ior_n    = ior_n_i;
  assign pif1.iow_n    = iow_n_i;

  gdp_pin_decode u_dec0 (
    .pif (pif0)
  );

  gdp_pin_decode u_dec1 (
    .pif (pif1)
  );

  // ----------------------------------------------------------------
  // Configuration port decode
  // ----------------------------------------------------------------
  logic cfg_cycle;
  logic idx_wr;
  logic idx_rd;
  logic dat_wr;
  logic dat_rd;

  // Ports answer only in extended mode with address enable low.
  assign cfg_cycle = ext_mode_i & ~aen_i;
  assign idx_wr    = cfg_cycle & ~iow_n_i & (sa_i == INDEX_PORT_ADDR);
  assign idx_rd    = cfg_cycle & ~ior_n_i & (sa_i == INDEX_PORT_ADDR);
  assign dat_wr    = cfg_cycle & ~iow_n_i & (sa_i == DATA_PORT_ADDR) & cfg_owned(state.index);
  assign dat_rd    = cfg_cycle & ~ior_n_i & (sa_i == DATA_PORT_ADDR) & cfg_owned(state.index);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Computes registers, pin drive and bus drive for the next edge.
  always_comb begin
    logic [7:0] mask;
    logic       hit_wr [2];
    logic       hit_rd [2];
    logic       cs_act [2];
    logic       cs_hi  [2];
    logic       oinv   [2];
    logic       iinv   [2];
    gdp_pkg::gdp_func_t fn [2];
    mask       = cfg_mask(state.index);
    next_state = state;
    next_state.sd_o  = 8'h00;
    next_state.sd_oe = 8'h00;

    hit_wr[0] = pif0.hit & ~iow_n_i;
    hit_rd[0] = pif0.hit & ~ior_n_i;
    cs_act[0] = pif0.cs_active;
    cs_hi[0]  = pif0.cs_high;
    oinv[0]   = pif0.out_inv;
    iinv[0]   = pif0.in_inv;
    fn[0]     = pif0.func;
    hit_wr[1] = pif1.hit & ~iow_n_i;
    hit_rd[1] = pif1.hit & ~ior_n_i;
    cs_act[1] = pif1.cs_active;
    cs_hi[1]  = pif1.cs_high;
    oinv[1]   = pif1.out_inv;
    iinv[1]   = pif1.in_inv;
    fn[1]     = pif1.func;

    // Index port write selects the register.
    if (idx_wr) begin
      next_state.index = sd_i;
    end
    // Data port write keeps reserved bits at zero.
    if (dat_wr) begin
      next_state.cfg[cfg_slot(state.index)] = sd_i & mask;
    end

    // Each pin k works on data bit k.
    for (int k = 0; k < 2; k++) begin
      unique case (fn[k])
        gdp_pkg::GDP_FN_OFF: begin
          next_state.pin_oe[k] = 1'b0;
        end
        // Latch data bit on matching write.
        gdp_pkg::GDP_FN_OUT: begin
          if (hit_wr[k]) begin
            next_state.latch[k] = sd_i[k] ^ oinv[k];
          end
          next_state.pin_oe[k] = 1'b1;
          next_state.pin_o[k]  = hit_wr[k] ? (sd_i[k] ^ oinv[k]) : state.latch[k];
        end
        // Pin level onto bus on matching read.
        gdp_pkg::GDP_FN_IN: begin
          next_state.pin_oe[k] = 1'b0;
          if (hit_rd[k]) begin
            next_state.sd_o[k]  = pin_i[k] ^ iinv[k];
            next_state.sd_oe[k] = 1'b1;
          end
        end
        gdp_pkg::GDP_FN_BIDIR: begin
          next_state.pin_oe[k] = hit_wr[k];
          next_state.pin_o[k]  = sd_i[k] ^ oinv[k];
          if (hit_rd[k]) begin
            next_state.sd_o[k]  = pin_i[k] ^ iinv[k];
            next_state.sd_oe[k] = 1'b1;
          end
        end
        gdp_pkg::GDP_FN_CS0, gdp_pkg::GDP_FN_CS1,
        gdp_pkg::GDP_FN_CS2, gdp_pkg::GDP_FN_CS3: begin
          next_state.pin_oe[k] = 1'b1;
          next_state.pin_o[k]  = cs_hi[k] ? cs_act[k] : ~cs_act[k];
        end
      endcase
    end

    // Configuration reads take the bus over any pin read.
    if (idx_rd) begin
      next_state.sd_o  = state.index;
      next_state.sd_oe = 8'hff;
    end else if (dat_rd) begin
      next_state.sd_o  = state.cfg[cfg_slot(state.index)];
      next_state.sd_oe = 8'hff;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything clears on reset.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state.index  <= `GDP_INDEX_RESET;
      state.cfg    <= {`GDP_NUM_CFG{`GDP_CFG_RESET}};
      state.latch  <= 2'h0;
      state.pin_o  <= 2'h0;
      state.pin_oe <= 2'h0;
      state.sd_o   <= 8'h00;
      state.sd_oe  <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign sd_o     = state.sd_o;
  assign sd_oe_o  = state.sd_oe;
  assign pin_o    = state.pin_o;
  assign pin_oe_o = state.pin_oe;

endmodule : gdp_decoded_pins

// *** bench/gdp_checker.sv ***
// Port checker of the decoded-pin block.
// Assumes binding to gdp_decoded_pins and a host that writes index then data.
`timescale 1ns/1ps
module gdp_checker #(
  parameter logic [10:0] INDEX_PORT_ADDR = 11'h100,
  parameter logic [10:0] DATA_PORT_ADDR  = 11'h101
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ext_mode_i,
  input wire logic        aen_i,
  input wire logic        ior_n_i,
  input wire logic        iow_n_i,
  input wire logic [10:0] sa_i,
  input wire logic [7:0]  sd_i,
  input wire logic [7:0]  sd_o,
  input wire logic [7:0]  sd_oe_o,
  input wire logic [1:0]  pin_i,
  input wire logic [1:0]  pin_o,
  input wire logic [1:0]  pin_oe_o
);
  logic [7:0]      idx;
  logic [5:0][7:0] sh;
  logic            acc;
  logic            wr_d;
  logic            rd_d;
  logic [1:0]      hit;
  logic [1:0]      cs;

  // Decode of config port cycles that reach a mapped register.
  assign acc  = ext_mode_i && !aen_i;
  assign wr_d = acc && !iow_n_i && sa_i == DATA_PORT_ADDR && idx inside {[8'h10:8'h15]};
  assign rd_d = acc && !ior_n_i && sa_i == DATA_PORT_ADDR && idx inside {[8'h10:8'h15]};

  // Shadow of the index and of the six registers, reserved bits dropped.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx <= 8'h00;
      sh  <= '0;
    end else begin
      if (acc && !iow_n_i && sa_i == INDEX_PORT_ADDR) begin
        idx <= sd_i;
      end
      if (wr_d) begin
        sh[idx[2:0]] <= (idx[0] && !idx[2]) ? (sd_i & 8'hc7) : sd_i;
      end
    end
  end

  // Masked address hit and qualified select of each pin.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      hit[k] = !aen_i && ((({sh[2*k+1][2:0], sh[2*k]} ^ sa_i) >> sh[2*k+1][7:6]) == 11'h000);
      cs[k]  = hit[k] && (sh[k+4][3:2] == 2'b00 || (sh[k+4][2] && !iow_n_i) || (sh[k+4][3] && !ior_n_i));
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_cfg_rd;
    rd_d;
  endsequence
  sequence s_wr_hit0;
    sh[4][7:5] == 3'b001 && hit[0] && !iow_n_i;
  endsequence

  property p_rd_drive; s_cfg_rd |=> sd_oe_o == 8'hff; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("config read not driven");
  property p_rd_value; s_cfg_rd |=> sd_o == $past(sh[idx[2:0]]); endproperty
  a_rd_value: assert property (p_rd_value) else $error("config read value wrong");
  property p_no_ext; !ext_mode_i && !sh[4][6] && !sh[5][6] |=> sd_oe_o == 8'h00; endproperty
  a_no_ext: assert property (p_no_ext) else $error("bus driven outside config mode");
  property p_rst; $rose(rstn_i) |-> pin_oe_o == 2'b00 && sd_oe_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_off; sh[4][7:5] == 3'b000 |=> !pin_oe_o[0]; endproperty
  a_off: assert property (p_off) else $error("inactive pin driven");
  property p_out; s_wr_hit0 |=> pin_oe_o[0] && pin_o[0] == $past(sd_i[0] ^ sh[4][1]); endproperty
  a_out: assert property (p_out) else $error("output pin value wrong");
  property p_in; sh[4][7:5] == 3'b010 && hit[0] && !ior_n_i && !rd_d
    && !(acc && sa_i == INDEX_PORT_ADDR)
    |=> sd_oe_o[0] && !pin_oe_o[0] && sd_o[0] == $past(pin_i[0] ^ sh[4][0]); endproperty
  a_in: assert property (p_in) else $error("input pin read wrong");
  property p_bidir; sh[4][7:5] == 3'b011 |=> pin_oe_o[0] == $past(hit[0] && !iow_n_i); endproperty
  a_bidir: assert property (p_bidir) else $error("bidir drive wrong");
  property p_cs0; sh[4][7] |=> pin_oe_o[0] && pin_o[0] == $past(cs[0] ~^ sh[4][4]); endproperty
  a_cs0: assert property (p_cs0) else $error("pin zero select wrong");
  property p_cs1; sh[5][7] |=> pin_oe_o[1] && pin_o[1] == $past(cs[1] ~^ sh[5][4]); endproperty
  a_cs1: assert property (p_cs1) else $error("pin one select wrong");
endmodule : gdp_checker

bind gdp_decoded_pins gdp_checker #(
  .INDEX_PORT_ADDR(INDEX_PORT_ADDR),
  .DATA_PORT_ADDR (DATA_PORT_ADDR)
) i_gdp_checker (
  .clk_i(clk_i), .rstn_i(rstn_i), .ext_mode_i(ext_mode_i), .aen_i(aen_i),
  .ior_n_i(ior_n_i), .iow_n_i(iow_n_i), .sa_i(sa_i), .sd_i(sd_i), .sd_o(sd_o),
  .sd_oe_o(sd_oe_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o)
);

// *** bench/gdp_host_model.sv ***
// Host bus master model issuing I/O cycles to the decoded-pin block.
// Assumes one sampling edge takes a request; lines are scrambled when idle.
`timescale 1ns/1ps
module gdp_host_model #(
  parameter logic [10:0] INDEX_PORT_ADDR = 11'h100,
  parameter logic [10:0] DATA_PORT_ADDR  = 11'h101
) (
  input  wire logic        clk_i,
  output logic             aen_o = 1'b1,
  output logic             ior_n_o = 1'b1,
  output logic             iow_n_o = 1'b1,
  output logic      [10:0] sa_o = 11'h000,
  output logic      [7:0]  sd_o = 8'h00
);
  // One cycle driven after an edge, held over the next sampling edge.
  task automatic cyc(input logic a, input logic rd, input logic wr, input logic [10:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    aen_o   <= a;
    ior_n_o <= !rd;
    iow_n_o <= !wr;
    sa_o    <= ad;
    sd_o    <= dt;
    @(posedge clk_i);
    #1;
  endtask : cyc

  // Strobes and address enable go high; address and data lines show the inverse of their last value.
  task automatic idle();
    @(posedge clk_i);
    aen_o   <= 1'b1;
    ior_n_o <= 1'b1;
    iow_n_o <= 1'b1;
    sa_o    <= ~sa_o;
    sd_o    <= ~sd_o;
  endtask : idle

  task automatic cfg(input logic rd, input logic [7:0] ix, input logic [7:0] dt);
    cyc(1'b0, 1'b0, 1'b1, INDEX_PORT_ADDR, ix);
    cyc(1'b0, rd, !rd, DATA_PORT_ADDR, dt);
  endtask : cfg
endmodule : gdp_host_model

// *** bench/gdp_decoded_pins_tb_top.sv ***
// Self-checking bench of the decoded-pin block.
// Assumes the host model drives the bus; pads are resolved here.
`timescale 1ns/1ps
module gdp_decoded_pins_tb_top;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ext_mode_i = 1'b0;
  logic [1:0]  ext_lvl = 2'b00;
  logic        aen, ior_n, iow_n, h, r, wv, eo, er;
  logic [10:0] sa, adr, ta;
  logic [7:0]  sd, sd_o, sd_oe_o, ctl, d;
  logic [1:0]  pin_i, pin_o, pin_oe_o, w;
  logic [31:0] rnd;
  logic [2:0]  fn;
  int          n_fail = 0;
  int          num_checks = 0;
  int          seed = 32'h680d4c2e;
  int          k;

  // Clock and pad resolution: a driven pin reads back its own level.
  always #5 clk_i = ~clk_i;
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_lvl);

  gdp_decoded_pins i_gdp_decoded_pins (
    .clk_i(clk_i), .rstn_i(rstn_i), .ext_mode_i(ext_mode_i), .aen_i(aen), .ior_n_i(ior_n),
    .iow_n_i(iow_n), .sa_i(sa), .sd_i(sd), .sd_o(sd_o), .sd_oe_o(sd_oe_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  gdp_host_model i_gdp_host_model (
    .clk_i(clk_i), .aen_o(aen), .ior_n_o(ior_n), .iow_n_o(iow_n), .sa_o(sa), .sd_o(sd));

  // Expected masked address hit.
  function automatic logic f_hit(input logic [10:0] p, input logic [10:0] a, input logic [1:0] wd);
    return (p >> wd) == (a >> wd);
  endfunction : f_hit

  // Expected select level from hit, qualifier, strobes and polarity.
  function automatic logic f_cs(input logic ht, input logic [1:0] q, input logic rd, input logic wr,
                                input logic pol);
    logic c;
    c = ht && (q == 2'b00 || (q[0] && wr) || (q[1] && rd));
    return pol ? c : !c;
  endfunction : f_cs

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung run.
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end

  // Reset, register checks, then random pin traffic on both pins.
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    i_gdp_host_model.cyc(1'b0, 1'b1, 1'b0, 11'h101, 8'h00);
    chk("oe_noext", 8'h00, sd_oe_o);
    @(posedge clk_i);
    ext_mode_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      i_gdp_host_model.cfg(1'b1, 8'(16 + i), 8'h00);
      chk("cfg_rst", 8'h00, sd_o);
      chk("cfg_oe", 8'hff, sd_oe_o);
    end
    i_gdp_host_model.cfg(1'b1, 8'h16, 8'h00);
    chk("unmapped_oe", 8'h00, sd_oe_o);
    for (int i = 0; i < 2; i++) begin
      i_gdp_host_model.cfg(1'b0, 8'(17 + 2 * i), 8'hff);
      i_gdp_host_model.cfg(1'b1, 8'(17 + 2 * i), 8'h00);
      chk("reserved", 8'hc7, sd_o);
    end
    for (int n = 0; n < 48; n++) begin
      k = n % 2;
      rnd = $random(seed);
      // Bit 9 kept high so pin traffic never lands on the index or data port.
      adr = {2'b11, rnd[8:0]};
      w = rnd[11:10];
      fn = 3'((n / 2) % 8);
      ctl = {fn, rnd[16:12]};
      d = rnd[24:17];
      i_gdp_host_model.cfg(1'b0, 8'(16 + 2 * k), adr[7:0]);
      i_gdp_host_model.cfg(1'b0, 8'(17 + 2 * k), {w, 3'b000, adr[10:8]});
      i_gdp_host_model.cfg(1'b0, 8'(20 + k), ctl);
      @(posedge clk_i);
      ext_lvl <= rnd[26:25];
      // hit inside ignored bits, or miss on bit 4
      ta = rnd[27] ? (adr ^ (rnd[10:0] & ~(11'h7ff << w))) : (adr ^ 11'h010);
      r = rnd[28];
      wv = rnd[29] && !rnd[28];
      h = f_hit(adr, ta, w) && !(rnd[30] && rnd[31]);
      i_gdp_host_model.cyc(rnd[30] && rnd[31], r, wv, ta, d);
      eo = fn == 3'b001 || fn[2] || (fn == 3'b011 && h && wv);
      er = fn[2:1] == 2'b01 && h && r;
      chk("pin_oe", 8'(eo), 8'(pin_oe_o[k]));
      if (fn[2]) begin
        chk("pin_cs", 8'(f_cs(h, ctl[3:2], r, wv, ctl[4])), 8'(pin_o[k]));
      end else if (fn[0] && h && wv) begin
        chk("pin_out", 8'(d[k] ^ ctl[1]), 8'(pin_o[k]));
      end
      chk("sd_oe", 8'(er), 8'(sd_oe_o[k]));
      if (er) begin
        chk("sd_in", 8'(ext_lvl[k] ^ ctl[0]), 8'(sd_o[k]));
      end
      i_gdp_host_model.idle();
    end
    tally_and_finish();
  end
endmodule : gdp_decoded_pins_tb_top
